// File: ccu_pkg.sv
// constants for the dual-array capture/compare unit
package ccu_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] ADR_TCTL = 12'h000; // four timer controls
  localparam logic [11:0] ADR_TVAL = 12'h010; // four timer counts
  localparam logic [11:0] ADR_TREL = 12'h020; // four reload values
  localparam logic [11:0] ADR_STS = 12'h030; // sticky event flags
  localparam logic [11:0] ADR_MASK = 12'h034; // interrupt mask
  localparam logic [11:0] ADR_CFG = 12'h038; // unit configuration
  localparam logic [11:0] ADR_CVAL = 12'h080; // 32 channel values
  localparam logic [11:0] ADR_CMOD = 12'h100; // 32 channel modes
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TC_PRE = 0; // prescale exponent, 3 bits
  localparam int TC_GPT = 3; // count on external timer overflow
  localparam int TC_EXT = 4; // count on count pin (first timers)
  localparam int TC_RUN = 5;
  localparam int CM_MODE = 0; // mode code, 3 bits
  localparam int CM_TSEL = 3; // 0 first time base, 1 second
  localparam int CM_DBL = 4; // double-register pairing
  localparam int CM_SINGLE = 5; // single-event option
  localparam int CFG_STAG = 0; // staggered operation
  // ----------------------------------------------------------------
  // mode codes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] M_OFF = 3'h0;
  localparam logic [2:0] M_CAP_RISE = 3'h1;
  localparam logic [2:0] M_CAP_FALL = 3'h2;
  localparam logic [2:0] M_CAP_BOTH = 3'h3;
  localparam logic [2:0] M_CMP0 = 3'h4;
  localparam logic [2:0] M_CMP1 = 3'h5;
  localparam logic [2:0] M_CMP2 = 3'h6;
  localparam logic [2:0] M_CMP3 = 3'h7;
  localparam logic [5:0] RST_TCTL = 6'h00;
  localparam logic [5:0] RST_CMOD = 6'h00;
  localparam logic [15:0] RST_VAL = 16'h0000;
  localparam logic [2:0] STAG_LAST = 3'h7; // eight cycles per step
endpackage : ccu_pkg

// File: dual_array_capture_compare.sv
// dual-array capture/compare unit with wishbone register access
// Functional notes
// R1 - Up to 32 channels resolve one clock, or eight when staggered.
// R2 - Four 16-bit timers with reload registers, two per array.
// R3 - Timers tick on a prescaled clock or on external timer overflows.
// R4 - The first time base of each array may count pin events.
// R5 - Each array has 16 registers, each on either time base, either role.
// R6 - Each register owns a pin, input when capturing, output comparing; the code drives it only in compare modes one and three.
// R7 - A capture latches the assigned timer on the selected pin event.
// R8 - Each capture raises that register's own interrupt request.
// R9 - Capture triggers on rising, falling or both edges.
// R10 - Compare registers match their timer on every count and act.
// R11 - Mode zero interrupts on every match and leaves the pin alone.
// R12 - Mode one toggles the pin on every match.
// R13 - Mode two interrupts at most once per timer period.
// R14 - Mode three sets the pin on match and clears it on overflow.
// R15 - Double-register mode toggles one pin from two registers.
// R16 - Single-event option stops a compare channel after one event.
// R17 - A timer reloads from its reload register on overflow.
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
module dual_array_capture_compare #(
  parameter int NCH = 16,
  parameter int TW = 16
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic [2*NCH-1:0] cc_in,
  output logic [2*NCH-1:0] cc_out,
  output logic [2*NCH-1:0] cc_oe_n,
  input wire logic [1:0] count_in,
  input wire logic gpt_overflow,
  output logic irq
);
  import ccu_pkg::*;
  localparam int NC = 2 * NCH;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic at(logic [11:0] a, logic [11:0] b);
    return a[11:2] == b[11:2];
  endfunction : at

  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n,
                                        logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  logic [5:0] tctl [4];
  logic [TW-1:0] tval [4];
  logic [TW-1:0] trel [4];
  logic [TW-1:0] cval [NC];
  logic [5:0] cmod [NC];
  logic [NC-1:0] sts, mask, in_d, done, cap, hit, ptog, evt;
  logic [3:0] step, cnt_evt, ovf_evt;
  logic [1:0] cin_d;
  logic [7:0] presc;
  logic [2:0] stag_cnt;
  logic stag, base_en, wr;
  logic [31:0] next_rdat;

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  // one wait state: ack and data rise together, ack drops next cycle
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (wb_cyc_i & wb_stb_i & ~wb_ack_o) begin
        wb_dat_o <= next_rdat;
      end
    end
  end

  // read mux; unmapped offsets answer zero
  always_comb begin
    next_rdat = 32'h00000000;
    for (int t = 0; t < 4; t++) begin
      if (at(wb_adr_i, ADR_TCTL + 12'(4 * t))) next_rdat = 32'(tctl[t]);
      if (at(wb_adr_i, ADR_TVAL + 12'(4 * t))) next_rdat = 32'(tval[t]);
      if (at(wb_adr_i, ADR_TREL + 12'(4 * t))) next_rdat = 32'(trel[t]);
    end
    for (int c = 0; c < NC; c++) begin
      if (at(wb_adr_i, ADR_CVAL + 12'(4 * c))) next_rdat = 32'(cval[c]);
      if (at(wb_adr_i, ADR_CMOD + 12'(4 * c))) next_rdat = 32'(cmod[c]);
    end
    if (at(wb_adr_i, ADR_STS)) next_rdat = 32'(sts);
    if (at(wb_adr_i, ADR_MASK)) next_rdat = 32'(mask);
    if (at(wb_adr_i, ADR_CFG)) next_rdat = 32'(stag);
  end

  // ----------------------------------------------------------------
  // configuration, mask, status
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stag <= 1'b0;
      mask <= '0;
    end else if (wr) begin
      if (at(wb_adr_i, ADR_CFG) && wb_sel_i[0]) stag <= wb_dat_i[CFG_STAG];
      if (at(wb_adr_i, ADR_MASK)) mask <= NC'(merge(32'(mask), wb_dat_i,
                                                    wb_sel_i));
    end
  end

  // write-one-to-clear; a new event in the same cycle keeps its flag
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sts <= '0;
    end else if (wr && at(wb_adr_i, ADR_STS)) begin
      sts <= (sts & ~NC'(merge(32'h0, wb_dat_i, wb_sel_i))) | evt; // R8
    end else begin
      sts <= sts | evt; // R8
    end
  end

  assign irq = |(sts & mask);

  // ----------------------------------------------------------------
  // prescaler and staggered pacing
  // ----------------------------------------------------------------
  // staggered operation stretches every prescaled count step eightfold; pin and overflow sources are not paced
  assign base_en = ~stag | (stag_cnt == STAG_LAST); // R1

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stag_cnt <= 3'h0;
      presc <= 8'h00;
      cin_d <= 2'h0;
    end else begin
      stag_cnt <= stag_cnt + 3'h1;
      cin_d <= count_in;
      if (base_en) presc <= presc + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // time bases: index 0,1 first array, 2,3 second array
  // ----------------------------------------------------------------
  for (genvar t = 0; t < 4; t++) begin : g_tmr
    logic [7:0] pm;
    logic tick_pre, ext_edge;
    assign pm = 8'((9'h001 << tctl[t][TC_PRE +: 3]) - 9'h001);
    assign tick_pre = base_en && ((presc & pm) == pm); // R3
    assign ext_edge = count_in[t/2] & ~cin_d[t/2]; // R4
    // an external source only counts when the timer runs
    assign step[t] = tctl[t][TC_RUN] &
      (((t % 2) == 0 && tctl[t][TC_EXT]) ? ext_edge : // R4
       tctl[t][TC_GPT] ? gpt_overflow : tick_pre); // R3

    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        tctl[t] <= RST_TCTL;
        trel[t] <= RST_VAL;
      end else if (wr) begin
        if (at(wb_adr_i, ADR_TCTL + 12'(4 * t))) begin
          tctl[t] <= 6'(merge(32'(tctl[t]), wb_dat_i, wb_sel_i));
        end
        if (at(wb_adr_i, ADR_TREL + 12'(4 * t))) begin
          trel[t] <= TW'(merge(32'(trel[t]), wb_dat_i, wb_sel_i)); // R2
        end
      end
    end

    // counting up; the all-ones count wraps to the reload value
    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        tval[t] <= RST_VAL;
        cnt_evt[t] <= 1'b0;
        ovf_evt[t] <= 1'b0;
      end else begin
        cnt_evt[t] <= step[t];
        ovf_evt[t] <= step[t] && (tval[t] == '1);
        if (wr && at(wb_adr_i, ADR_TVAL + 12'(4 * t))) begin
          tval[t] <= TW'(merge(32'(tval[t]), wb_dat_i, wb_sel_i));
        end else if (step[t]) begin
          if (tval[t] == '1) tval[t] <= trel[t]; // R17
          else tval[t] <= tval[t] + 1'b1; // R2
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NC; c++) begin : g_ch
    // lower half of each array may pair with the channel NCH/2 above
    localparam int P = ((c % NCH) < NCH / 2) ? c + NCH / 2 : c;
    logic [1:0] ti;
    logic [2:0] md;
    logic rise, fall, once, match;
    assign ti = {1'(c / NCH), cmod[c][CM_TSEL]}; // R5
    assign md = cmod[c][CM_MODE +: 3];
    assign rise = cc_in[c] & ~in_d[c];
    assign fall = ~cc_in[c] & in_d[c];
    assign cap[c] = (md == M_CAP_RISE && rise) || // R9
                    (md == M_CAP_FALL && fall) || // R9
                    (md == M_CAP_BOTH && (rise || fall)); // R9
    // compared right after each count of the allocated timer
    assign match = md[2] && cnt_evt[ti] && (tval[ti] == cval[c]); // R10
    assign once = (md == M_CMP2) || (md == M_CMP3);
    assign hit[c] = match && !(once && done[c]); // R13
    assign ptog[c] = (P != c) && cmod[c][CM_DBL] && hit[P]; // R15
    assign evt[c] = cap[c] | hit[c]; // R11
    // the pin is driven only in the pin-acting compare modes
    assign cc_oe_n[c] = !(md == M_CMP1 || md == M_CMP3); // R6

    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        in_d[c] <= 1'b0;
        done[c] <= 1'b0;
      end else begin
        in_d[c] <= cc_in[c];
        if (hit[c]) done[c] <= 1'b1; // R13
        else if (ovf_evt[ti]) done[c] <= 1'b0; // R13
      end
    end

    // capture wins over a bus write in the same cycle
    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        cval[c] <= RST_VAL;
      end else if (cap[c]) begin
        cval[c] <= tval[ti]; // R7
      end else if (wr && at(wb_adr_i, ADR_CVAL + 12'(4 * c))) begin
        cval[c] <= TW'(merge(32'(cval[c]), wb_dat_i, wb_sel_i));
      end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        cmod[c] <= RST_CMOD;
      end else if (wr && at(wb_adr_i, ADR_CMOD + 12'(4 * c))) begin
        cmod[c] <= 6'(merge(32'(cmod[c]), wb_dat_i, wb_sel_i)); // R5
      end else if (hit[c] && cmod[c][CM_SINGLE]) begin
        cmod[c][CM_MODE +: 3] <= M_OFF; // R16
      end
    end

    // pin actions; modes zero and two leave the pin alone
    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        cc_out[c] <= 1'b0;
      end else if (md == M_CMP1 && (hit[c] ^ ptog[c])) begin
        cc_out[c] <= ~cc_out[c]; // R12 R15
      end else if (md == M_CMP3 && hit[c]) begin
        cc_out[c] <= 1'b1; // R14
      end else if (md == M_CMP3 && ovf_evt[ti]) begin
        cc_out[c] <= 1'b0; // R14
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions on time bases 0 and 1 and the exercised channels
  // ----------------------------------------------------------------
  // channel roles in the test sequence: 0 to 3 compare modes zero to
  // three, 4 single event, 5 paired with 13, 9 and 17 capture; a check
  // on an idle channel would never see its antecedent
  logic wr_t0;
  logic [2:0] md0, md1, md2, md3, md5, md9, md17;
  logic [3:0] gap_cnt;
  assign wr_t0 = wr && at(wb_adr_i, ADR_TVAL);
  assign md0 = cmod[0][CM_MODE +: 3];
  assign md1 = cmod[1][CM_MODE +: 3];
  assign md2 = cmod[2][CM_MODE +: 3];
  assign md3 = cmod[3][CM_MODE +: 3];
  assign md5 = cmod[5][CM_MODE +: 3];
  assign md9 = cmod[9][CM_MODE +: 3];
  assign md17 = cmod[17][CM_MODE +: 3];

  // clocks since the last base tick; restarts whenever staggering is off
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      gap_cnt <= 4'h0;
    end else if (base_en || !stag) begin
      gap_cnt <= 4'h0;
    end else begin
      gap_cnt <= gap_cnt + 4'h1;
    end
  end

  // while staggered, base ticks come exactly eight clocks apart
  AST_STAG: assert property (@(posedge clock) disable iff (sys_rst) // R1
    stag && base_en |=> (!stag || !base_en) [*7])
    else $error("stagger pacing too fast");
  AST_STAG_GAP: assert property (@(posedge clock) disable iff (sys_rst) // R1
    stag && gap_cnt == 4'h7 |-> base_en)
    else $error("stagger pacing too slow");

  // time base 0 counts up and wraps to its reload value
  AST_INC: assert property (@(posedge clock) disable iff (sys_rst) // R2
    step[0] && tval[0] != '1 && !wr_t0 |=> tval[0] == $past(tval[0]) + 1'b1)
    else $error("timer did not count");
  AST_RELOAD: assert property (@(posedge clock) disable iff (sys_rst) // R17
    step[0] && tval[0] == '1 && !wr_t0 |=> tval[0] == $past(trel[0]) &&
    ovf_evt[0]) else $error("timer did not reload");
  // event-driven bases move only on their own event
  AST_EXT_COUNT: assert property (@(posedge clock) disable iff (sys_rst) // R4
    tctl[0][TC_EXT] && !(count_in[0] && !cin_d[0]) |-> !step[0])
    else $error("count pin stepped without an edge");
  AST_GPT: assert property (@(posedge clock) disable iff (sys_rst) // R3
    tctl[1][TC_GPT] && !gpt_overflow |-> !step[1])
    else $error("overflow source stepped on its own");

  // capture: channel 9 on rising edges, channel 17 on falling edges; pin drive on channels 9 and 1
  AST_CAPTURE: assert property (@(posedge clock) disable iff (sys_rst) // R7
    cap[9] |=> cval[9] == $past(tval[g_ch[9].ti]))
    else $error("capture value wrong");
  AST_CAP_FLAG: assert property (@(posedge clock) disable iff (sys_rst) // R8
    cap[9] |=> sts[9]) else $error("capture flag missing");
  AST_EDGE: assert property (@(posedge clock) disable iff (sys_rst) // R9
    md9 == M_CAP_RISE && !(cc_in[9] && !in_d[9]) |-> !cap[9])
    else $error("capture on wrong edge");
  AST_FALL: assert property (@(posedge clock) disable iff (sys_rst) // R9
    md17 == M_CAP_FALL && !(in_d[17] && !cc_in[17]) |-> !cap[17])
    else $error("capture on wrong falling edge");
  AST_OE: assert property (@(posedge clock) disable iff (sys_rst) // R6
    !md9[2] |-> cc_oe_n[9]) else $error("capture pin driven");
  AST_DRIVE: assert property (@(posedge clock) disable iff (sys_rst) // R6
    md1 == M_CMP1 |-> !cc_oe_n[1]) else $error("compare pin not driven");

  // compare modes
  AST_MATCH: assert property (@(posedge clock) disable iff (sys_rst) // R10
    md0 == M_CMP0 && !cmod[0][CM_TSEL] && cnt_evt[0] &&
    tval[0] == cval[0] |-> hit[0]) else $error("match missed");
  AST_MODE0: assert property (@(posedge clock) disable iff (sys_rst) // R11
    md0 == M_CMP0 && hit[0] |=> sts[0] && $stable(cc_out[0]))
    else $error("mode zero misbehaved");
  AST_MODE1: assert property (@(posedge clock) disable iff (sys_rst) // R12
    md1 == M_CMP1 && hit[1] && !ptog[1] |=> cc_out[1] != $past(cc_out[1]))
    else $error("mode one did not toggle");
  AST_MODE2: assert property (@(posedge clock) disable iff (sys_rst) // R13
    md2 == M_CMP2 && done[2] |-> !hit[2]) else $error("second interrupt");
  AST_MODE2_PIN: assert property (@(posedge clock) disable iff (sys_rst) // R13
    md2 == M_CMP2 && hit[2] |=> sts[2] && $stable(cc_out[2]))
    else $error("mode two misbehaved");
  AST_MODE3: assert property (@(posedge clock) disable iff (sys_rst) // R14
    md3 == M_CMP3 && ovf_evt[g_ch[3].ti] && !hit[3] |=> !cc_out[3])
    else $error("mode three pin not cleared");
  AST_MODE3_SET: assert property (@(posedge clock) disable iff (sys_rst) // R14
    md3 == M_CMP3 && hit[3] |=> cc_out[3]) else $error("mode three not set");
  AST_DOUBLE: assert property (@(posedge clock) disable iff (sys_rst) // R15
    md5 == M_CMP1 && cmod[5][CM_DBL] && (hit[5] ^ hit[13]) |=>
    cc_out[5] != $past(cc_out[5])) else $error("paired pin did not toggle");
  AST_SINGLE: assert property (@(posedge clock) disable iff (sys_rst) // R16
    hit[4] && cmod[4][CM_SINGLE] && !wr |=> cmod[4][CM_MODE +: 3] == M_OFF)
    else $error("single event not stopped");

  // status flags: a new event survives a same-cycle clear
  AST_STS_SET: assert property (@(posedge clock) disable iff (sys_rst) // R8
    |evt |=> (sts & $past(evt)) == $past(evt))
    else $error("event flag lost");
  AST_IRQ: assert property (@(posedge clock) disable iff (sys_rst) // R8
    !wr && (mask & evt) != '0 |=> irq)
    else $error("interrupt level wrong");

  // main scenarios
  COV_CAPTURE: cover property (@(posedge clock) disable iff (sys_rst)
    cap[9] ##1 sts[9]);
  COV_MODE3: cover property (@(posedge clock) disable iff (sys_rst)
    md3 == M_CMP3 && hit[3] ##[1:300] ovf_evt[g_ch[3].ti]);
  COV_DOUBLE: cover property (@(posedge clock) disable iff (sys_rst)
    ptog[5] && md5 == M_CMP1);
  COV_RELOAD: cover property (@(posedge clock) disable iff (sys_rst)
    ovf_evt[0]);
endmodule : dual_array_capture_compare

// File: ccu_pins_model.sv
// far-side model: channel pins, count pins and external timer overflow
`timescale 1ns/1ns
module ccu_pins_model (
  input wire logic clock,
  input wire logic [31:0] cc_out,
  input wire logic [31:0] cc_oe_n,
  output logic [31:0] cc_in,
  output logic [1:0] count_in,
  output logic gpt_overflow
);
  logic [31:0] ext_level;
  // a pin the unit drives reads back its own level, others the source
  assign cc_in = (cc_out & ~cc_oe_n) | (ext_level & cc_oe_n);
  initial begin
    ext_level = 32'h00000000;
    count_in = 2'h0;
    gpt_overflow = 1'b0;
  end
  // one external transition, launched just after an edge
  task automatic set_pin(input int c, input logic v);
    @(posedge clock);
    ext_level[c] <= v;
  endtask : set_pin
  // one-cycle pulse on count pin k, or on the overflow line for k = 2
  task automatic pulse(input int k);
    @(posedge clock);
    if (k < 2) begin
      count_in[k] <= 1'b1;
    end else begin
      gpt_overflow <= 1'b1;
    end
    @(posedge clock);
    count_in <= 2'h0;
    gpt_overflow <= 1'b0;
    @(posedge clock);
  endtask : pulse
endmodule : ccu_pins_model

// File: test_dual_array_capture_compare.sv
// self-checking bench for the dual-array capture/compare unit
`timescale 1ns/1ns
module test_dual_array_capture_compare;
  import ccu_pkg::*;
  logic clock, sys_rst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic irq, gpt_overflow;
  logic [11:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, cc_in, cc_out, cc_oe_n, rd;
  logic [31:0] prev_out = 32'h00000000;
  logic [3:0] wb_sel_i;
  logic [1:0] count_in;
  logic [15:0] v;
  int error_cnt = 0;
  int samples_checked = 0;
  int tog [8];
  int n, c, t;
  bit hit;
  dual_array_capture_compare uut (.clock(clock), .sys_rst(sys_rst),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cc_in(cc_in),
    .cc_out(cc_out), .cc_oe_n(cc_oe_n), .count_in(count_in),
    .gpt_overflow(gpt_overflow), .irq(irq));
  ccu_pins_model pins (.clock(clock), .cc_out(cc_out), .cc_oe_n(cc_oe_n),
    .cc_in(cc_in), .count_in(count_in), .gpt_overflow(gpt_overflow));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // pin activity model: count every level change on the first channels
  always @(posedge clock) begin
    for (int i = 0; i < 8; i++) begin
      if (cc_out[i] !== prev_out[i]) tog[i]++;
    end
    prev_out <= cc_out;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check
  // one classic cycle; read data lands in rd at the ack edge
  task automatic wb(input int a, input logic we, input logic [31:0] d);
    int k;
    @(posedge clock);
    wb_adr_i <= 12'(a);
    wb_we_i <= we;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (k >= 20) begin
      error_cnt++;
      report_and_stop();
    end
  endtask : wb
  initial begin
    sys_rst = 1'b1;
    {wb_we_i, wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hF;
    void'($urandom(32'hEE532A19));
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    // ----------------------------------------------------------------
    // reset values, an unmapped place, 16-bit reload width
    // ----------------------------------------------------------------
    foreach (tog[i]) begin
      wb(32'h3C + i * 4 * (i % 2) + (i % 2 ? 0 : i * 64), 0, 0);
      check("reset read", 32'h0, rd);
    end
    wb(32'h03C, 1, 32'hFFFFFFFF);
    wb(32'h03C, 0, 0);
    check("unmapped read", 32'h0, rd);
    check("idle enables", 32'hFFFFFFFF, cc_oe_n);
    v = 16'($urandom());
    wb(ADR_TREL, 1, {16'hFFFF, v});
    wb(ADR_TREL, 0, 0);
    check("reload width", {16'h0, v}, rd);
    $display("test reset done");
    // ----------------------------------------------------------------
    // timer sources: count pins on first bases, overflows on second
    // ----------------------------------------------------------------
    for (t = 0; t < 4; t++) begin
      n = 1 + $urandom_range(4);
      wb(ADR_TVAL + 4 * t, 1, 0);
      wb(ADR_TCTL + 4 * t, 1, (t % 2) ? 32'h28 : 32'h30);
      repeat (n) pins.pulse((t % 2) ? 2 : t / 2);
      wb(ADR_TCTL + 4 * t, 1, 0);
      wb(ADR_TVAL + 4 * t, 0, 0);
      check("timer count", n, rd);
    end
    // staggered operation: one step per eight clocks
    wb(ADR_TVAL + 4, 1, 0);
    wb(ADR_CFG, 1, 1);
    wb(ADR_TCTL + 4, 1, 32'h20);
    repeat (78) @(posedge clock);
    wb(ADR_TCTL + 4, 1, 0);
    wb(ADR_CFG, 1, 0);
    wb(ADR_TVAL + 4, 0, 0);
    check("staggered steps", 1, rd >= 9 && rd <= 11);
    // prescaled source: exponent 3 gives one step per eight clocks
    wb(ADR_TVAL + 8, 1, 0);
    wb(ADR_TCTL + 8, 1, 32'h23);
    repeat (78) @(posedge clock);
    wb(ADR_TCTL + 8, 1, 0);
    wb(ADR_TVAL + 8, 0, 0);
    check("prescaled steps", 1, rd >= 9 && rd <= 11);
    $display("test timers done");
    // ----------------------------------------------------------------
    // capture on rise, fall and both, timers frozen at random counts
    // ----------------------------------------------------------------
    for (int m = 1; m < 4; m++) begin
      c = 8 * m + 1;
      t = (c / 16) * 2 + m % 2;
      wb(ADR_CMOD + 4 * c, 1, m | ((m % 2) << CM_TSEL));
      wb(ADR_MASK, 1, 32'h1 << c);
      for (int e = 1; e >= 0; e--) begin
        v = 16'($urandom());
        wb(ADR_TVAL + 4 * t, 1, v);
        pins.set_pin(c, e[0]);
        repeat (3) @(posedge clock);
        hit = (m == 3) || (m == 1 && e == 1) || (m == 2 && e == 0);
        wb(ADR_STS, 0, 0);
        check("capture flag", hit ? 32'h1 << c : 0, rd);
        check("capture irq", hit, irq);
        wb(ADR_CVAL + 4 * c, 0, 0);
        if (hit) check("captured value", v, rd);
        wb(ADR_STS, 1, 32'hFFFFFFFF);
        check("cleared irq", 0, irq);
      end
      wb(ADR_CMOD + 4 * c, 1, 0);
    end
    wb(ADR_MASK, 1, 0);
    $display("test capture done");
    // ----------------------------------------------------------------
    // compare modes on a 16-count period, single event, double pin
    // ----------------------------------------------------------------
    wb(ADR_TREL, 1, 32'hFFF0);
    wb(ADR_TVAL, 1, 32'hFFF0);
    for (int i = 0; i < 6; i++) begin
      wb(ADR_CVAL + 4 * i, 1, i == 5 ? 32'hFFF4 : 32'hFFF8);
      wb(ADR_CMOD + 4 * i, 1, i < 4 ? M_CMP0 + i : (i == 4 ? 32'h25 : 32'h15));
    end
    wb(ADR_CVAL + 52, 1, 32'hFFFA);
    wb(ADR_CMOD + 52, 1, M_CMP0);
    foreach (tog[i]) tog[i] = 0;
    wb(ADR_TCTL, 1, 32'h20);
    repeat (139) @(posedge clock);
    wb(ADR_TCTL, 1, 0);
    repeat (4) @(posedge clock);
    check("mode0 pin", 0, tog[0]);
    check("mode1 toggles", 9, tog[1]);
    check("mode2 pin", 0, tog[2]);
    check("mode3 edges", 17, tog[3]);
    check("single toggles", 1, tog[4]);
    check("double toggles", 18, tog[5]);
    check("enables", 32'hFFFFFFD5, cc_oe_n);
    wb(ADR_CMOD + 16, 0, 0);
    check("single mode off", 32'h1 << CM_SINGLE, rd);
    wb(ADR_STS, 0, 0);
    check("compare flags", 32'h0000203F, rd);
    check("masked irq", 0, irq);
    wb(ADR_MASK, 1, 32'hFFFFFFFF);
    check("unmasked irq", 1, irq);
    wb(ADR_STS, 1, 32'hFFFFFFFF);
    check("cleared irq", 0, irq);
    $display("test compare done");
    report_and_stop();
  end
endmodule : test_dual_array_capture_compare
